//--- fpr_map.svh
`ifndef FPR_MAP_SVH
`define FPR_MAP_SVH
// Serial opcodes
`define FPR_OP_WREN 8'h06
`define FPR_OP_WRDI 8'h04
`define FPR_OP_WRSR 8'h01
`define FPR_OP_RDSR 8'h05
`define FPR_OP_PROG 8'h02
`define FPR_OP_ERASE4K 8'h20
`define FPR_OP_ERASE32K 8'h52
`define FPR_OP_ERASE64K 8'hd8
`define FPR_OP_CHIP1 8'hc7
`define FPR_OP_CHIP2 8'h60
`define FPR_OP_RST_ARM 8'h66
`define FPR_OP_RST_GO 8'h99
// Array geometry for the protect decode
`define FPR_ARRAY_TOP 23'h400000
`define FPR_UNIT_BIG 23'h010000
`define FPR_UNIT_SMALL 23'h001000
`define FPR_SMALL_MAX 23'h008000
// Protection bit positions inside the six-bit field
`define FPR_CMP_POS 5
`define FPR_BP4_POS 4
`define FPR_BP3_POS 3
// APB byte offsets
`define FPR_REG_STATUS 8'h00
`define FPR_REG_VOLATILE 8'h04
`define FPR_REG_LASTOP 8'h08
`define FPR_REG_PROBE 8'h0c
// Reset values
`define FPR_PROT_RST 6'h00
`define FPR_VOL_RST 13'h0000
// Volatile register fields
`define FPR_VOL_ESUS_POS 11
`define FPR_VOL_PSUS_POS 12
// Software reset recovery time
`define FPR_T_RESET_US 30
`define FPR_CLK_MHZ 40
`define FPR_RESET_CYCLES (`FPR_T_RESET_US * `FPR_CLK_MHZ)
`define FPR_TIMER_W 12
`endif

//--- fpr_pkg.sv
`include "fpr_map.svh"
package fpr_pkg;
  typedef enum logic [1:0] {
    FPR_ST_OPCODE,
    FPR_ST_ADDR,
    FPR_ST_DATA,
    FPR_ST_SKIP
  } fpr_state_t;

  typedef enum logic [1:0] {
    FPR_KIND_NONE,
    FPR_KIND_PROGRAM,
    FPR_KIND_ERASE,
    FPR_KIND_CHIP
  } fpr_kind_t;

  // Size of the protected block for a code; low code 0 and 7 are handled by the caller
  function automatic logic [22:0] fpr_prot_size(input logic [5:0] bits);
    logic [2:0] low;
    low = bits[2:0];
    if (bits[`FPR_BP4_POS]) begin
      fpr_prot_size = (low >= 3'h4) ? `FPR_SMALL_MAX : (`FPR_UNIT_SMALL << (low - 3'h1));
    end else begin
      fpr_prot_size = `FPR_UNIT_BIG << (low - 3'h1);
    end
  endfunction

  // Protected test on the 22 meaningful address bits
  function automatic logic fpr_is_protected(input logic [5:0] bits, input logic [21:0] addr);
    logic [22:0] size;
    logic in_rng;
    size = fpr_prot_size(bits);
    if (bits[2:0] == 3'h0) begin
      in_rng = 1'b0;
    end else if (bits[2:0] == 3'h7) begin
      in_rng = 1'b1;
    end else if (bits[`FPR_BP3_POS]) begin
      in_rng = {1'b0, addr} < size;
    end else begin
      in_rng = {1'b0, addr} >= (`FPR_ARRAY_TOP - size);
    end
    fpr_is_protected = in_rng ^ bits[`FPR_CMP_POS];
  endfunction

  // True when no address at all is protected
  function automatic logic fpr_prot_none(input logic [5:0] bits);
    fpr_prot_none = bits[`FPR_CMP_POS] ? (bits[2:0] == 3'h7) : (bits[2:0] == 3'h0);
  endfunction
endpackage

//--- fpr_reset_seq.sv
`timescale 1ns/1ps
`include "fpr_map.svh"
module fpr_reset_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic cmd_aligned,
  output logic armed,
  output logic reset_fire,
  output logic busy
);
  localparam logic [`FPR_TIMER_W-1:0] RESET_LAST = `FPR_TIMER_W'(`FPR_RESET_CYCLES - 1);
  logic armed_reg;
  logic fire_reg;
  logic busy_reg;
  logic [`FPR_TIMER_W-1:0] timer_reg;
  wire is_arm = cmd_aligned & (cmd_opcode == `FPR_OP_RST_ARM);
  wire is_go = cmd_aligned & (cmd_opcode == `FPR_OP_RST_GO);

  assign armed = armed_reg;
  assign reset_fire = fire_reg;
  assign busy = busy_reg;

  // Arm, fire and recovery timer; frames are ignored while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
      fire_reg <= 1'b0;
      busy_reg <= 1'b0;
      timer_reg <= '0;
    end else if (ce) begin
      fire_reg <= 1'b0;
      if (busy_reg) begin
        timer_reg <= timer_reg - `FPR_TIMER_W'(1);
        busy_reg <= (timer_reg != '0);
      end else if (cmd_valid) begin
        armed_reg <= is_arm;
        if (is_go && armed_reg) begin
          fire_reg <= 1'b1;
          busy_reg <= 1'b1;
          timer_reg <= RESET_LAST;
        end
      end
    end
  end
endmodule

//--- fpr_spi_front.sv
`timescale 1ns/1ps
module fpr_spi_front (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  fpr_spi_if.front link
);
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic sclk_d_reg;
  logic cs_d_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic seen_reg;
  logic byte_valid_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic fresh_reg;
  wire cs_n_s = sync2_reg[2];
  wire sclk_s = sync2_reg[1];
  wire mosi_s = sync2_reg[0];
  wire rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
  wire fall = ~sclk_s & sclk_d_reg & ~cs_n_s;

  // Frame edges and byte framing
  assign link.frame_start = ~cs_n_s & cs_d_reg;
  assign link.frame_end = cs_n_s & ~cs_d_reg;
  assign link.frame_aligned = (bit_cnt_reg == 3'h0) & seen_reg;
  assign link.byte_valid = byte_valid_reg;
  assign link.rx_byte = rx_reg;
  assign spi_miso = tx_reg[7];
  assign spi_miso_oe_n = cs_n_s;

  // Two-stage synchronisers; pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 3'h4;
      sync2_reg <= 3'h4;
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end else if (ce) begin
      sync1_reg <= {spi_cs_n, spi_sclk, spi_mosi};
      sync2_reg <= sync1_reg;
      sclk_d_reg <= sclk_s;
      cs_d_reg <= cs_n_s;
    end
  end

  // Receive shifter, sampled on the serial rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
      seen_reg <= 1'b0;
      byte_valid_reg <= 1'b0;
      rx_reg <= 8'h00;
    end else if (ce) begin
      byte_valid_reg <= rise & (bit_cnt_reg == 3'h7);
      if (link.frame_start) begin
        bit_cnt_reg <= 3'h0;
        seen_reg <= 1'b0;
      end else if (rise) begin
        shift_reg <= {shift_reg[5:0], mosi_s};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          rx_reg <= {shift_reg, mosi_s};
          seen_reg <= 1'b1;
        end
      end
    end
  end

  // Transmit shifter; first falling edge after a load only presents the msb
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_reg <= 8'h00;
      fresh_reg <= 1'b0;
    end else if (ce) begin
      if (link.tx_load) begin
        tx_reg <= link.tx_byte;
        fresh_reg <= 1'b1;
      end else if (fall) begin
        if (fresh_reg) begin
          fresh_reg <= 1'b0;
        end else begin
          tx_reg <= {tx_reg[6:0], 1'b0};
        end
      end
    end
  end
endmodule

//--- fpr_spi_host.sv
`timescale 1ns/1ps
// Serial host, mode 0, four pclk per sclk phase, sclk idle low between frames
module fpr_spi_host (
  input wire logic pclk,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire logic spi_miso
);
  logic [7:0] rx_byte;
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
    rx_byte = 8'h00;
  end
  // Top n bits of d, msb first; whole bytes unless a torn frame is wanted
  task automatic xfer(input logic [39:0] d, input int n);
    spi_cs_n <= 1'b0;
    for (int i = 39; i > 39 - n; i--) begin
      spi_mosi <= d[i];
      repeat (4) @(posedge pclk);
      spi_sclk <= 1'b1;
      rx_byte <= {rx_byte[6:0], spi_miso};
      repeat (4) @(posedge pclk);
      spi_sclk <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    spi_cs_n <= 1'b1;
    // Released line must not keep showing the last bit
    spi_mosi <= ~spi_mosi;
    repeat (8) @(posedge pclk);
  endtask
endmodule

//--- fpr_spi_if.sv
`timescale 1ns/1ps
interface fpr_spi_if;
  logic byte_valid;
  logic [7:0] rx_byte;
  logic frame_start;
  logic frame_end;
  logic frame_aligned;
  logic tx_load;
  logic [7:0] tx_byte;
  modport front (output byte_valid, rx_byte, frame_start, frame_end, frame_aligned,
                 input tx_load, tx_byte);
  modport core (input byte_valid, rx_byte, frame_start, frame_end, frame_aligned,
                output tx_load, tx_byte);
endinterface

//--- fpr_top.sv
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "fpr_map.svh"
// What this block does
// - Protected region follows complement select and five block-protect bits, set by status write.
// - Complement clear and low code 000 leaves the whole array unprotected.
// - Complement clear, upper pair 00: codes 1..6 protect top 1/64 to 1/2.
// - Complement clear, upper pair 01: codes 1..6 protect bottom 1/64 to 1/2.
// - Complement clear and low code 111 protects the entire array.
// - Upper pair 10: top 4k, 8k, 16k, then 32k for codes 10x and 110.
// - Upper pair 11: bottom 4k, 8k, 16k, then 32k for codes 10x and 110.
// - Complement set protects exactly the inverse of the complement-clear region.
// - Write-protect pin never changes the region, only locks the protection bits.
// - Write-protect pin low refuses every change of the protection bits.
// - Software reset needs the arm command directly followed by the execute command.
// - Any other command after arming drops the armed state.
// - Accepted reset aborts operations and clears volatile bits, latch, suspend, mode, wrap.
// - About 30 us of reset recovery during which every command is rejected.
// - Commands act at chip-select release only on a whole-byte boundary.
// - Program, erase and status write need the write-enable latch set first.
module fpr_top
  import fpr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  input wire logic wp_n,
  output logic op_valid,
  output fpr_kind_t op_kind,
  output logic [21:0] op_addr,
  output logic op_abort
);
  fpr_spi_if link ();

  // Frame tracking state
  fpr_state_t state_reg;
  fpr_state_t state_next;
  logic [2:0] byte_cnt_reg;
  logic [7:0] opcode_reg;
  logic [23:0] addr_reg;
  logic [7:0] data_reg;

  // Protection and latch state
  logic [5:0] prot_reg;
  logic [5:0] prot_next;
  logic wel_reg;
  logic wel_next;
  logic wp_s1_reg;
  logic wp_s2_reg;

  // Software-visible state
  logic [12:0] vol_reg;
  logic [21:0] probe_reg;
  logic [21:0] last_addr_reg;
  logic last_ok_reg;
  logic last_rej_reg;

  // Array request outputs
  logic op_valid_reg;
  fpr_kind_t op_kind_reg;
  logic [21:0] op_addr_reg;

  logic rst_armed;
  logic rst_fire;
  logic rst_busy;

  fpr_spi_front u_front (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe_n(spi_miso_oe_n),
    .link(link)
  );

  // Frame end with at least one whole opcode, outside reset recovery
  wire frame_ok = link.frame_end & (byte_cnt_reg != 3'h0);
  wire cmd_end = frame_ok & ~rst_busy;
  wire aligned = link.frame_aligned;

  fpr_reset_seq u_reset (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .cmd_valid(frame_ok),
    .cmd_opcode(opcode_reg),
    .cmd_aligned(aligned),
    .armed(rst_armed),
    .reset_fire(rst_fire),
    .busy(rst_busy)
  );

  // Opcode classes
  wire is_wren = opcode_reg == `FPR_OP_WREN;
  wire is_wrdi = opcode_reg == `FPR_OP_WRDI;
  wire is_wrsr = opcode_reg == `FPR_OP_WRSR;
  wire is_rdsr = opcode_reg == `FPR_OP_RDSR;
  wire is_prog = opcode_reg == `FPR_OP_PROG;
  wire is_erase = (opcode_reg == `FPR_OP_ERASE4K) | (opcode_reg == `FPR_OP_ERASE32K) |
                  (opcode_reg == `FPR_OP_ERASE64K);
  wire is_chip = (opcode_reg == `FPR_OP_CHIP1) | (opcode_reg == `FPR_OP_CHIP2);
  wire is_array = is_prog | is_erase | is_chip;
  wire needs_wel = is_array | is_wrsr;

  // Frame length each command needs: opcode, three address bytes, data
  wire shape_ok = (is_prog & (byte_cnt_reg >= 3'h5)) | (is_erase & (byte_cnt_reg == 3'h4)) |
                  (is_chip & (byte_cnt_reg == 3'h1)) | (is_wrsr & (byte_cnt_reg == 3'h2));
  wire suspended = vol_reg[`FPR_VOL_ESUS_POS] | vol_reg[`FPR_VOL_PSUS_POS];

  // Protection lookups for the command address and the software probe
  wire cmd_prot = fpr_is_protected(prot_reg, addr_reg[21:0]);
  wire probe_prot = fpr_is_protected(prot_reg, probe_reg);
  wire prot_none = fpr_prot_none(prot_reg);
  wire target_prot = is_chip ? ~prot_none : cmd_prot;

  // Execution decisions at chip-select release
  wire whole = cmd_end & aligned;
  wire array_go = whole & is_array & shape_ok & wel_reg;
  wire op_fire = array_go & ~target_prot;
  wire op_reject = array_go & target_prot;
  // Status write is ignored outright while a suspend is pending; latch kept
  wire wrsr_go = whole & is_wrsr & shape_ok & wel_reg & ~suspended;
  wire prot_write = wrsr_go & wp_s2_reg;
  wire bad_frame = cmd_end & needs_wel & wel_reg & (~aligned | ~shape_ok) &
                   ~(is_wrsr & suspended);
  wire wel_set = whole & is_wren;
  wire wel_clr = (whole & is_wrdi) | array_go | wrsr_go | bad_frame;

  // Latch next value; the reset sequence overrides everything
  assign wel_next = rst_fire ? 1'b0 : (wel_clr ? 1'b0 : (wel_set ? 1'b1 : wel_reg));
  // Protection bits move only by an accepted status write; the pin gates the update only
  assign prot_next = prot_write ? data_reg[7:2] : prot_reg;

  // Status byte: {cmp, bp4..bp0, latch, busy}
  wire [7:0] status_byte = {prot_reg, wel_reg, rst_busy};
  assign link.tx_byte = status_byte;
  assign link.tx_load = link.byte_valid & ~rst_busy &
                        (((state_reg == FPR_ST_OPCODE) & (link.rx_byte == `FPR_OP_RDSR)) |
                         ((state_reg == FPR_ST_DATA) & is_rdsr));

  // Byte-phase sequencing within a frame
  always_comb begin
    state_next = state_reg;
    if (link.frame_start) begin
      state_next = FPR_ST_OPCODE;
    end else if (link.byte_valid) begin
      case (state_reg)
        FPR_ST_OPCODE: begin
          if ((link.rx_byte == `FPR_OP_PROG) || (link.rx_byte == `FPR_OP_ERASE4K) ||
              (link.rx_byte == `FPR_OP_ERASE32K) || (link.rx_byte == `FPR_OP_ERASE64K)) begin
            state_next = FPR_ST_ADDR;
          end else if ((link.rx_byte == `FPR_OP_WRSR) || (link.rx_byte == `FPR_OP_RDSR)) begin
            state_next = FPR_ST_DATA;
          end else begin
            state_next = FPR_ST_SKIP;
          end
        end
        FPR_ST_ADDR: begin
          if (byte_cnt_reg == 3'h3) begin
            state_next = FPR_ST_DATA;
          end
        end
        FPR_ST_DATA: state_next = FPR_ST_DATA;
        FPR_ST_SKIP: state_next = FPR_ST_SKIP;
        default: state_next = FPR_ST_SKIP;
      endcase
    end
  end

  // Frame registers; byte count saturates, long program data is not counted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= FPR_ST_OPCODE;
      byte_cnt_reg <= 3'h0;
      opcode_reg <= 8'h00;
    end else if (ce) begin
      state_reg <= state_next;
      if (link.frame_start) begin
        byte_cnt_reg <= 3'h0;
      end else if (link.byte_valid && byte_cnt_reg != 3'h7) begin
        byte_cnt_reg <= byte_cnt_reg + 3'h1;
      end
      if (link.byte_valid && state_reg == FPR_ST_OPCODE) begin
        opcode_reg <= link.rx_byte;
      end
    end
  end

  // Address capture, and the data byte right after the opcode (status write)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= 24'h000000;
      data_reg <= 8'h00;
    end else if (ce && link.byte_valid) begin
      if (state_reg == FPR_ST_ADDR) begin
        addr_reg <= {addr_reg[15:0], link.rx_byte};
      end
      if (state_reg == FPR_ST_DATA && byte_cnt_reg == 3'h1) begin
        data_reg <= link.rx_byte;
      end
    end
  end

  // Write-protect pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_s1_reg <= 1'b0;
      wp_s2_reg <= 1'b0;
    end else if (ce) begin
      wp_s1_reg <= wp_n;
      wp_s2_reg <= wp_s1_reg;
    end
  end

  // Latch and protection bits; protection survives a software reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wel_reg <= 1'b0;
      prot_reg <= `FPR_PROT_RST;
    end else if (ce) begin
      wel_reg <= wel_next;
      prot_reg <= prot_next;
    end
  end

  // Array request port, one pulse per accepted program or erase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_valid_reg <= 1'b0;
      op_kind_reg <= FPR_KIND_NONE;
      op_addr_reg <= 22'h000000;
    end else if (ce) begin
      op_valid_reg <= op_fire;
      if (op_fire) begin
        op_kind_reg <= is_prog ? FPR_KIND_PROGRAM : (is_erase ? FPR_KIND_ERASE : FPR_KIND_CHIP);
        op_addr_reg <= addr_reg[21:0];
      end
    end
  end

  // Outcome of the last array command, for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_addr_reg <= 22'h000000;
      last_ok_reg <= 1'b0;
      last_rej_reg <= 1'b0;
    end else if (ce && array_go) begin
      last_addr_reg <= addr_reg[21:0];
      last_ok_reg <= op_fire;
      last_rej_reg <= op_reject;
    end
  end

  assign op_valid = op_valid_reg;
  assign op_kind = op_kind_reg;
  assign op_addr = op_addr_reg;
  assign op_abort = rst_fire;

  // APB decode; slave always answers in the access cycle unless frozen
  wire hit_status = paddr == `FPR_REG_STATUS;
  wire hit_vol = paddr == `FPR_REG_VOLATILE;
  wire hit_last = paddr == `FPR_REG_LASTOP;
  wire hit_probe = paddr == `FPR_REG_PROBE;
  wire mapped = hit_status | hit_vol | hit_last | hit_probe;
  wire apb_acc = psel & penable & ce;
  wire apb_wr = apb_acc & pwrite & mapped;

  assign pready = ce;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = ({32{hit_status}} & {21'h0, prot_none, wp_s2_reg, rst_armed,
                                        status_byte}) |
                  ({32{hit_vol}} & {19'h0, vol_reg}) |
                  ({32{hit_last}} & {6'h0, last_rej_reg, last_ok_reg, 2'h0, last_addr_reg}) |
                  ({32{hit_probe}} & {probe_prot, 9'h0, probe_reg});

  // Volatile settings: mode byte, wrap bits, suspend flags; software reset clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vol_reg <= `FPR_VOL_RST;
    end else if (ce) begin
      if (rst_fire) begin
        vol_reg <= `FPR_VOL_RST;
      end else if (apb_wr && hit_vol) begin
        vol_reg <= pwdata[12:0];
      end
    end
  end

  // Probe address; lets software ask whether any address is protected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      probe_reg <= 22'h000000;
    end else if (apb_wr && hit_probe) begin
      probe_reg <= pwdata[21:0];
    end
  end
endmodule

//--- fpr_top_properties.sv
`timescale 1ns/1ps
`include "fpr_map.svh"
module fpr_prop_chk
  import fpr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe_n,
  input wire logic op_valid,
  input wire fpr_kind_t op_kind,
  input wire logic [21:0] op_addr,
  input wire logic op_abort
);
  logic [11:0] busy_cnt;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Recovery window, kept two short so edge slack never fires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 12'h000;
    end else if (op_abort) begin
      busy_cnt <= 12'(`FPR_RESET_CYCLES - 2);
    end else if (busy_cnt != 12'h000) begin
      busy_cnt <= busy_cnt - 12'h001;
    end
  end

  // Bus answer and error timing
  pready_run_a: assert property (pready == ce)
    else $error("pready differs from ce");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  unmapped_err_a: assert property (psel && penable && paddr[7:4] != 4'h0 |-> pslverr)
    else $error("unmapped not flagged");
  // Array operations are single pulses after a closed frame
  op_pulse_a: assert property (op_valid |=> !op_valid)
    else $error("op_valid too long");
  op_framed_a: assert property (op_valid || op_abort |-> spi_cs_n && $past(spi_cs_n, 2))
    else $error("operation inside open frame");
  op_hold_a: assert property (!op_valid |-> $stable(op_kind) && $stable(op_addr))
    else $error("op fields moved");
  abort_pulse_a: assert property (op_abort |=> !op_abort)
    else $error("op_abort too long");
  quiet_reset_a: assert property (busy_cnt != 12'h000 |-> !op_valid && !op_abort)
    else $error("command taken while resetting");
  // Driver stays off between frames
  oe_idle_a: assert property (spi_cs_n [*4] |-> spi_miso_oe_n)
    else $error("miso driven outside frame");
  none_flag_a: assert property (psel && paddr == `FPR_REG_STATUS |->
    prdata[10] == (prdata[7] ? prdata[4:2] == 3'h7 : prdata[4:2] == 3'h0))
    else $error("nothing-protected flag wrong");
  chip_seen_c: cover property (op_valid && op_kind == FPR_KIND_CHIP);
  abort_seen_c: cover property (op_abort);
  err_seen_c: cover property (pslverr);
endmodule

bind fpr_top fpr_prop_chk fpr_prop_chk_inst (.*);

//--- tb_top.sv
`timescale 1ns/1ps
`include "fpr_map.svh"
module tb_top;
  import fpr_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, wp_n, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe_n;
  logic op_valid, op_abort;
  logic [21:0] op_addr, a_seen;
  fpr_kind_t op_kind, k_seen;
  int error_cnt, compares, cyc, seed, s, n_op, m_op, n_ab, m_ab;
  int m_bits, m_wel, m_arm, m_vol, t_rst;
  int q[$];
  int ops[9] = '{2, 'h20, 'h52, 'hd8, 2, 'hc7, 'h60, 'hc7, 'h60};
  int ads[9] = '{'h3f0000, 'h3fffff, 'h100, 'h3effff, 'hc00010, 0, 0, 0, 0};

  fpr_top fpr_top_inst (.*);
  fpr_spi_host host (.*);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Cycle count, op monitor, hang guard at nearly three times the expected run
  always @(posedge pclk) begin
    cyc++;
    if (op_valid === 1'b1) begin
      n_op++;
      k_seen = op_kind;
      a_seen = op_addr;
    end
    if (op_abort === 1'b1) n_ab++;
    if (cyc == 60000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Reference region size and membership, from the protect tables
  function automatic int sz(input int b);
    int c;
    c = b & 7;
    return b[4] ? 4096 << (c > 3 ? 3 : c - 1) : 65536 << (c - 1);
  endfunction
  function automatic int prot(input int b, input int a);
    int c, m;
    c = b & 7;
    m = c == 7 || (c != 0 && (b[3] ? a < sz(b) : a >= 'h400000 - sz(b)));
    return m ^ b[5];
  endfunction

  task automatic probe(input int a);
    apb(1'b1, 8'h0c, a);
    apb(1'b0, 8'h0c, 32'h0);
    chk({rd[31], rd[21:0]}, {1'(prot(m_bits, a)), 22'(a)});
  endtask

  task automatic st();
    int nb;
    nb = m_bits[5] ? m_bits[2:0] == 3'h7 : m_bits[2:0] == 3'h0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[10:2], {nb[0], wp_n, m_arm[0], m_bits[5:0]});
    chk(rd[0], cyc - t_rst < `FPR_RESET_CYCLES);
    if (m_wel >= 0) chk(rd[1], m_wel);
  endtask

  // One serial command, then the reference model steps and is compared
  task automatic cmd(input logic [7:0] op, input int ad, input int n);
    int pa, e, k;
    pa = m_arm;
    k = op == 8'h02 ? 1 : op inside {8'h20, 8'h52, 8'hd8} ? 2 : op inside {8'hc7, 8'h60} ? 3 : 0;
    host.xfer({op, ad[23:0], 8'h5a}, n);
    if (cyc - t_rst < `FPR_RESET_CYCLES) return;
    // A frame without one whole opcode byte is no command and leaves the arm alone
    if (n >= 8) m_arm = n % 8 == 0 && op == 8'h66;
    if (n % 8 != 0) return;
    if (op == 8'h06) m_wel = 1;
    if (op == 8'h04) m_wel = 0;
    if (op == 8'h99 && pa) begin
      t_rst = cyc;
      m_wel = 0;
      m_vol = 0;
      m_ab++;
    end
    if (op == 8'h01 && m_wel == 1 && m_vol[12:11] == 2'b00) begin
      if (wp_n) m_bits = ad[23:18];
      m_wel = 0;
    end
    if (k != 0 && m_wel == 1) begin
      e = k == 3 ? prot(m_bits ^ 'h20, 0) == 0 || prot(m_bits, 'h3fffff) : prot(m_bits, ad & 'h3fffff);
      m_wel = 0;
      m_op += !e;
      apb(1'b0, 8'h08, 32'h0);
      chk(rd[25:24], {e[0], !e[0]});
      if (!e) chk(k_seen, k);
      if (!e && k < 3) chk(a_seen, ad[21:0]);
    end
    chk(n_op, m_op);
    chk(n_ab, m_ab);
  endtask

  initial begin
    seed = 32'hcc02;
    t_rst = -100000;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wp_n = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, 8'h10, 32'h1);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h00, 32'hff);
    st();
    ce <= 1'b0;
    fork
      apb(1'b1, 8'h0c, 32'h123);
      begin
        repeat (4) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd[21:0], 22'h123);
    $display("Done: register bus");
    for (int b = 0; b < 64; b++) begin
      cmd(8'h06, 0, 8);
      cmd(8'h01, b << 18, 16);
      st();
      s = sz(b);
      q = '{0, s - 1, s, 'h3fffff - s, 'h400000 - s, 'h3fffff, $random(seed)};
      foreach (q[i]) probe(q[i] & 'h3fffff);
    end
    $display("Done: protect decode");
    wp_n <= 1'b0;
    cmd(8'h06, 0, 8);
    cmd(8'h01, 1 << 18, 16);
    st();
    probe(0);
    probe('h3fffff);
    // Status byte over the serial line, second byte of a status read
    cmd(8'h06, 0, 8);
    cmd(8'h05, 0, 16);
    chk(host.rx_byte, {m_bits[5:0], m_wel[0], 1'b0});
    wp_n <= 1'b1;
    $display("Done: write protect pin");
    cmd(8'h06, 0, 8);
    cmd(8'h01, 1 << 18, 16);
    cmd(8'h04, 0, 8);
    cmd(8'h02, 'h100, 40);
    foreach (ops[i]) begin
      if (i == 7) begin
        cmd(8'h06, 0, 8);
        cmd(8'h01, 0, 16);
      end
      cmd(8'h06, 0, 8);
      cmd(ops[i], ads[i], ops[i] == 2 ? 40 : ops[i] inside {'hc7, 'h60} ? 8 : 32);
    end
    $display("Done: array commands");
    apb(1'b1, 8'h04, 32'h7ff);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[12:0], 13'h7ff);
    m_vol = 'h7ff;
    st();
    cmd(8'h06, 0, 8);
    cmd(8'h66, 0, 8);
    st();
    cmd(8'h99, 0, 8);
    st();
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[12:0], m_vol);
    cmd(8'h06, 0, 8);
    st();
    do apb(1'b0, 8'h00, 32'h0); while (rd[0] === 1'b1);
    chk(cyc - t_rst > 1180 && cyc - t_rst < 1220, 1);
    repeat (10) @(posedge pclk);
    cmd(8'h66, 0, 8);
    cmd(8'h06, 0, 8);
    cmd(8'h99, 0, 8);
    cmd(8'h66, 0, 8);
    cmd(8'h04, 0, 7);
    cmd(8'h99, 0, 8);
    st();
    $display("Done: software reset");
    end_of_test();
  end
endmodule
